// [inc/fwr_pkg.sv]
package fwr_pkg;
  // Opcodes
  localparam logic [7:0] OP_QREAD   = 8'heb;
  localparam logic [7:0] OP_WRAP    = 8'h77;
  localparam logic [7:0] OP_RST_EN  = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  localparam logic [7:0] OP_PDOWN   = 8'hb9;
  localparam logic [7:0] OP_RELEASE = 8'hab;
  localparam logic [7:0] OP_MFR_ID  = 8'h90;

  // Wrap byte layout and reset values, quad enable bit, continuous mode code
  localparam int         WRAP_DIS_POS  = 4;
  localparam int         WRAP_LEN_LSB  = 5;
  localparam logic       WRAP_DIS_RST  = 1'b1;
  localparam logic [1:0] WRAP_LEN_RST  = 2'h0;
  localparam logic [5:0] WRAP_MASK_MAX = 6'h3f;
  localparam int         QE_POS        = 1;
  localparam logic [1:0] CONT_MODE     = 2'h2;

  // Phase lengths in serial clocks
  localparam logic [4:0] Q_ADDR_CLK = 5'h06;
  localparam logic [4:0] Q_MODE_CLK = 5'h02;
  localparam logic [4:0] Q_DUM_CLK  = 5'h04;
  localparam logic [4:0] S_ADDR_CLK = 5'h18;
  localparam logic [4:0] WRAP_CLK   = 5'h08;
  localparam logic [4:0] OP_CLK     = 5'h08;

  // Timing
  localparam int          CLK_NS          = 20;
  localparam int          PDOWN_ENTRY_NS  = 3000;
  localparam int          RELEASE_NS      = 3000;
  localparam int          RELEASE_ID_NS   = 5000;
  localparam logic [15:0] PDOWN_ENTRY_CYC = 16'((PDOWN_ENTRY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RELEASE_CYC     = 16'((RELEASE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RELEASE_ID_CYC  = 16'((RELEASE_ID_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CS_GAP_CYC      = 16'h0004;
  localparam logic [7:0]  SCLK_HALF_CYC   = 8'h04;
endpackage

// [inc/fwr_if.sv]
`timescale 1ns/1ns
interface fwr_if;
  logic       cs_n;
  logic       sclk;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  // Weak pull-up where nobody drives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = d_io_oe[i] ? d_io_o[i] : (h_io_oe[i] ? h_io_o[i] : 1'b1);
    end
  end

  modport dev  (input cs_n, sclk, io, output d_io_o, d_io_oe);
  modport host (output cs_n, sclk, h_io_o, h_io_oe, input io);
endinterface

// [logic/fwr_dev.sv]
// Functional notes
// - Wrapped quad reads loop inside section
// - 77h, 24 dummy bits, wrap byte
// - Wrap disable bit zero enables wrapping
// - Length field selects 8/16/32/64 bytes
// - Wrap disabled after power-on
// - Wrap setting persists for later reads
// - Quad commands need quad enable bit
// - Software reset restores power-on state
// - Reset ignored in deep power-down
// - Reset ignored in continuous read mode
// - 66h must directly precede 99h
// - Host checks busy before reset; fwr_host has no busy input and does not check it
// - B9h needs chip select right after
// - Power-down accepts only ABh
// - Power-up in normal operation
// - ABh alone releases after wait
// - ABh plus dummies repeats device ID
// - Host waits longer after ID release
// - ABh ignored while busy
// - 90h alternates manufacturer and device ID
// - Latch on rise, drive on fall
// - Continuous mode skips the opcode
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ns
module fwr_dev #(
  parameter logic [7:0] MFR_ID = 8'h5a,  // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'h3c   // Arbitrary value
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Link
  fwr_if.dev               dif,
  // Core side
  input  wire logic [7:0]  status_register_two_i,
  input  wire logic        busy_i,
  input  wire logic [7:0]  rd_data_i,
  output logic      [23:0] rd_addr_o,
  output logic             wrap_disable_o,
  output logic      [1:0]  wrap_length_o,
  output logic             powered_down_o,
  output logic             cont_read_o,
  output logic             soft_reset_o
);
  typedef enum logic [3:0] {
    S_IDLE, S_OP, S_ADDR, S_MODE, S_DUM, S_QOUT, S_SOUT, S_WRAP, S_IGN
  } fwr_dst_t;

  typedef struct packed {
    fwr_dst_t    st;
    logic        cs_m;
    logic        cs;
    logic        cs_d;
    logic        ck_m;
    logic        ck;
    logic        ck_d;
    logic [3:0]  io_m;
    logic [3:0]  io;
    logic [4:0]  cnt;
    logic [23:0] sh;
    logic [7:0]  op;
    logic [23:0] addr;
    logic [7:0]  obyte;
    logic [2:0]  bcnt;
    logic        idsel;
    logic        nib;
    logic [3:0]  dout;
    logic [3:0]  doe;
    logic        wrap_dis;
    logic [1:0]  wrap_len;
    logic        pd;
    logic        arm;
    logic        cont;
    logic        extra;
    logic        idrd;
    logic        dp_pend;
    logic [15:0] tmr;
    logic        srst;
  } fwr_dev_t;

  localparam fwr_dev_t DEV_RST = '{
    st: S_IDLE, cs_m: 1'b1, cs: 1'b1, cs_d: 1'b1,
    wrap_dis: fwr_pkg::WRAP_DIS_RST, wrap_len: fwr_pkg::WRAP_LEN_RST,
    default: '0
  };

  fwr_dev_t r;
  fwr_dev_t next_r;
  logic        rise;
  logic        fall;
  logic        qe;
  logic        quad;
  logic [7:0]  opc;
  logic [7:0]  wbyte;
  logic [7:0]  idb;
  logic [23:0] wmask;
  logic [23:0] inc;
  logic [4:0]  last;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.srst = 1'b0;
    // Pins pass two flops before use
    next_r.cs_m = dif.cs_n;
    next_r.cs   = r.cs_m;
    next_r.cs_d = r.cs;
    next_r.ck_m = dif.sclk;
    next_r.ck   = r.ck_m;
    next_r.ck_d = r.ck;
    next_r.io_m = dif.io;
    next_r.io   = r.io_m;
    rise  = r.ck & ~r.ck_d;
    fall  = ~r.ck & r.ck_d;
    qe    = status_register_two_i[fwr_pkg::QE_POS];
    quad  = (r.op == fwr_pkg::OP_QREAD);
    opc   = {r.sh[6:0], r.io[0]};
    wbyte = {r.sh[3:0], r.io};
    idb   = r.idsel ? DEV_ID : MFR_ID;
    wmask = r.wrap_dis ? 24'hffffff
                       : {18'h0, fwr_pkg::WRAP_MASK_MAX >> (2'h3 - r.wrap_len)};
    inc   = r.addr + 24'h000001;
    last  = quad ? fwr_pkg::Q_ADDR_CLK - 5'h01 : fwr_pkg::S_ADDR_CLK - 5'h01;

    if (r.tmr != 16'h0) begin
      next_r.tmr = r.tmr - 16'h0001;
    end else if (r.dp_pend) begin
      next_r.pd      = 1'b1;
      next_r.dp_pend = 1'b0;
    end

    if (r.cs && !r.cs_d) begin
      next_r.st  = S_IDLE;
      next_r.doe = 4'h0;
      if (r.pd && r.op == fwr_pkg::OP_RELEASE) begin
        next_r.pd  = 1'b0;
        next_r.tmr = r.idrd ? fwr_pkg::RELEASE_ID_CYC : fwr_pkg::RELEASE_CYC;
      end else if (r.op == fwr_pkg::OP_PDOWN && !r.extra) begin
        next_r.dp_pend = 1'b1;
        next_r.tmr     = fwr_pkg::PDOWN_ENTRY_CYC;
      end
    end else if (!r.cs && r.cs_d) begin
      next_r.op    = 8'h00;
      next_r.extra = 1'b0;
      next_r.idrd  = 1'b0;
      next_r.cnt   = 5'h00;
      next_r.sh    = 24'h0;
      if (r.tmr != 16'h0 || r.dp_pend) begin
        next_r.st = S_IGN;
      end else if (r.cont) begin
        next_r.st = S_ADDR;
        next_r.op = fwr_pkg::OP_QREAD;
      end else begin
        next_r.st = S_OP;
      end
    end else if (!r.cs) begin
      case (r.st)
        S_OP: begin
          if (rise) begin
            next_r.sh  = {r.sh[22:0], r.io[0]};
            next_r.cnt = r.cnt + 5'h01;
            if (r.cnt == fwr_pkg::OP_CLK - 5'h01) begin
              next_r.cnt = 5'h00;
              next_r.op  = opc;
              next_r.st  = S_IGN;
              next_r.arm = 1'b0;
              if (r.pd) begin
                if (opc == fwr_pkg::OP_RELEASE && !busy_i) begin
                  next_r.st = S_DUM;
                end else begin
                  next_r.op = 8'h00;
                end
              end else begin
                case (opc)
                  fwr_pkg::OP_QREAD: if (qe) next_r.st = S_ADDR;
                  fwr_pkg::OP_WRAP:  if (qe) next_r.st = S_WRAP;
                  fwr_pkg::OP_MFR_ID: next_r.st = S_ADDR;
                  fwr_pkg::OP_RELEASE: begin
                    if (!busy_i) next_r.st = S_DUM;
                    else next_r.op = 8'h00;
                  end
                  fwr_pkg::OP_RST_EN: next_r.arm = 1'b1;
                  fwr_pkg::OP_RST: begin
                    if (r.arm) begin
                      next_r.wrap_dis = fwr_pkg::WRAP_DIS_RST;
                      next_r.wrap_len = fwr_pkg::WRAP_LEN_RST;
                      next_r.srst     = 1'b1;
                    end
                  end
                  default: next_r.st = S_IGN;
                endcase
              end
            end
          end
        end
        S_ADDR: begin
          if (rise) begin
            next_r.sh  = quad ? {r.sh[19:0], r.io} : {r.sh[22:0], r.io[0]};
            next_r.cnt = r.cnt + 5'h01;
            if (r.cnt == last) begin
              next_r.cnt  = 5'h00;
              next_r.addr = next_r.sh;
              next_r.bcnt = 3'h0;
              // address bit zero picks first ID
              next_r.idsel = next_r.sh[0];
              next_r.st    = quad ? S_MODE : S_SOUT;
            end
          end
        end
        S_MODE: begin
          if (rise) begin
            next_r.sh  = {r.sh[19:0], r.io};
            next_r.cnt = r.cnt + 5'h01;
            if (r.cnt == fwr_pkg::Q_MODE_CLK - 5'h01) begin
              // mode bits set or clear continuous
              next_r.cont = (r.sh[1:0] == fwr_pkg::CONT_MODE);
              next_r.cnt  = 5'h00;
              next_r.st   = S_DUM;
            end
          end
        end
        S_DUM: begin
          if (rise) begin
            next_r.cnt = r.cnt + 5'h01;
            if (r.cnt == (quad ? fwr_pkg::Q_DUM_CLK : fwr_pkg::S_ADDR_CLK) - 5'h01) begin
              next_r.cnt   = 5'h00;
              next_r.nib   = 1'b0;
              next_r.bcnt  = 3'h0;
              next_r.idsel = 1'b1;
              next_r.idrd  = !quad;
              next_r.st    = quad ? S_QOUT : S_SOUT;
            end
          end
        end
        S_QOUT: begin
          if (fall) begin
            next_r.doe = 4'hf;
            next_r.nib = ~r.nib;
            if (!r.nib) begin
              next_r.dout  = rd_data_i[7:4];
              next_r.obyte = rd_data_i;
            end else begin
              next_r.dout = r.obyte[3:0];
              next_r.addr = (r.addr & ~wmask) | (inc & wmask);
            end
          end
        end
        S_SOUT: begin
          if (fall) begin
            next_r.doe  = 4'h2;
            next_r.bcnt = r.bcnt + 3'h1;
            if (r.bcnt == 3'h0) begin
              next_r.dout  = {2'h0, idb[7], 1'b0};
              next_r.obyte = {idb[6:0], 1'b0};
            end else begin
              next_r.dout  = {2'h0, r.obyte[7], 1'b0};
              next_r.obyte = {r.obyte[6:0], 1'b0};
            end
            if (r.bcnt == 3'h7 && r.op == fwr_pkg::OP_MFR_ID) begin
              next_r.idsel = ~r.idsel;
            end
          end
        end
        S_WRAP: begin
          if (rise) begin
            next_r.sh  = {r.sh[19:0], r.io};
            next_r.cnt = r.cnt + 5'h01;
            if (r.cnt == fwr_pkg::WRAP_CLK - 5'h01) begin
              // only bits six to four kept
              next_r.wrap_dis = wbyte[fwr_pkg::WRAP_DIS_POS];
              next_r.wrap_len = wbyte[fwr_pkg::WRAP_LEN_LSB +: 2];
              next_r.st       = S_IGN;
            end
          end
        end
        S_IGN: begin
          if (rise) next_r.extra = 1'b1;
        end
        default: next_r.st = S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset constant: wrap off, awake
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= DEV_RST;
    end else begin
      r <= next_r;
    end
  end

  assign dif.d_io_o     = r.dout;
  assign dif.d_io_oe    = r.doe;
  assign rd_addr_o      = r.addr;
  assign wrap_disable_o = r.wrap_dis;
  assign wrap_length_o  = r.wrap_len;
  assign powered_down_o = r.pd;
  assign cont_read_o    = r.cont;
  assign soft_reset_o   = r.srst;
endmodule

// [logic/fwr_host.sv]
`timescale 1ns/1ns
module fwr_host #(
  parameter logic [7:0] HALF_CYC = fwr_pkg::SCLK_HALF_CYC
) (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // Command port
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  opcode_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [7:0]  wrap_byte_i,
  input  wire logic [7:0]  mode_i,
  input  wire logic        skip_opcode_i,
  input  wire logic [7:0]  read_bytes_i,
  output logic             ready_o,
  output logic      [7:0]  rd_data_o,
  output logic             rd_valid_o,
  output logic             done_o,
  // Link
  fwr_if.host              hif
);
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} fwr_hst_t;

  typedef struct packed {
    fwr_hst_t    st;
    logic [7:0]  div;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  io_m;
    logic [3:0]  io;
    logic [7:0]  op_sh;
    logic [3:0]  op_n;
    logic [47:0] tx_sh;
    logic [5:0]  tx_n;
    logic        txq;
    logic        rxq;
    logic        rx_on;
    logic [7:0]  rx_n;
    logic [2:0]  rx_k;
    logic [7:0]  rx_sh;
    logic [3:0]  dout;
    logic [3:0]  doe;
    logic [15:0] gap;
    logic        ready;
    logic [7:0]  rdat;
    logic        rvalid;
    logic        done;
  } fwr_host_t;

  localparam fwr_host_t HOST_RST = '{st: H_IDLE, cs_n: 1'b1, ready: 1'b1, default: '0};

  fwr_host_t r;
  fwr_host_t next_r;
  logic       drive;
  logic [7:0] smp;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r = r;
    next_r.rvalid = 1'b0;
    next_r.done   = 1'b0;
    next_r.io_m   = hif.io;
    next_r.io     = r.io_m;
    drive = 1'b0;
    smp   = r.rxq ? {r.rx_sh[3:0], r.io} : {r.rx_sh[6:0], r.io[1]};
    case (r.st)
      H_IDLE: begin
        if (cmd_valid_i) begin
          next_r.st    = H_RUN;
          next_r.ready = 1'b0;
          next_r.cs_n  = 1'b0;
          next_r.div   = 8'h00;
          next_r.op_sh = opcode_i;
          next_r.op_n  = skip_opcode_i ? 4'h0 : 4'h8;
          next_r.tx_sh = 48'h0;
          next_r.tx_n  = 6'h00;
          next_r.txq   = 1'b0;
          next_r.rxq   = 1'b0;
          next_r.rx_n  = 8'h00;
          next_r.rx_k  = 3'h0;
          next_r.rx_on = 1'b0;
          next_r.gap   = fwr_pkg::CS_GAP_CYC;
          case (opcode_i)
            fwr_pkg::OP_QREAD: begin
              next_r.tx_sh = {addr_i, mode_i, 16'h0};
              next_r.tx_n  = 6'd12;
              next_r.txq   = 1'b1;
              next_r.rxq   = 1'b1;
              next_r.rx_n  = read_bytes_i;
            end
            fwr_pkg::OP_WRAP: begin
              // dummy bits then wrap byte, quad
              next_r.tx_sh = {24'h0, wrap_byte_i, 16'h0};
              next_r.tx_n  = 6'd8;
              next_r.txq   = 1'b1;
            end
            fwr_pkg::OP_MFR_ID: begin
              next_r.tx_sh = {addr_i, 24'h0};
              next_r.tx_n  = 6'd24;
              next_r.rx_n  = read_bytes_i;
            end
            fwr_pkg::OP_RELEASE: begin
              next_r.tx_n = (read_bytes_i != 8'h00) ? 6'd24 : 6'd0;
              next_r.rx_n = read_bytes_i;
              next_r.gap  = (read_bytes_i != 8'h00) ? fwr_pkg::RELEASE_ID_CYC
                                                    : fwr_pkg::RELEASE_CYC;
            end
            fwr_pkg::OP_PDOWN: next_r.gap = fwr_pkg::PDOWN_ENTRY_CYC;
            default: next_r.gap = fwr_pkg::CS_GAP_CYC;
          endcase
          drive = 1'b1;
        end
      end
      H_RUN: begin
        next_r.div = r.div + 8'h01;
        if (r.div == HALF_CYC - 8'h01) begin
          next_r.div  = 8'h00;
          next_r.sclk = ~r.sclk;
          if (!r.sclk) begin
            if (r.op_n != 4'h0) begin
              next_r.op_sh = {r.op_sh[6:0], 1'b0};
              next_r.op_n  = r.op_n - 4'h1;
            end else if (r.tx_n != 6'h00) begin
              next_r.tx_sh = r.txq ? {r.tx_sh[43:0], 4'h0} : {r.tx_sh[46:0], 1'b0};
              next_r.tx_n  = r.tx_n - 6'h01;
            end else begin
              next_r.rx_on = 1'b1;
            end
          end else begin
            // Sample just before the next falling edge
            if (r.rx_on) begin
              next_r.rx_on = 1'b0;
              next_r.rx_sh = smp;
              next_r.rx_k  = r.rx_k + 3'h1;
              if (r.rx_k == (r.rxq ? 3'h1 : 3'h7)) begin
                next_r.rx_k   = 3'h0;
                next_r.rdat   = smp;
                next_r.rvalid = 1'b1;
                next_r.rx_n   = r.rx_n - 8'h01;
              end
            end
            // chip select rises after last bit
            if (r.op_n == 4'h0 && r.tx_n == 6'h00 && next_r.rx_n == 8'h00) begin
              next_r.cs_n = 1'b1;
              next_r.doe  = 4'h0;
              next_r.st   = H_GAP;
            end else begin
              drive = 1'b1;
            end
          end
        end
      end
      H_GAP: begin
        if (r.gap != 16'h0) begin
          next_r.gap = r.gap - 16'h0001;
        end else begin
          next_r.st    = H_IDLE;
          next_r.ready = 1'b1;
          next_r.done  = 1'b1;
        end
      end
      default: next_r.st = H_IDLE;
    endcase
    // Present the next bit after a falling edge
    if (drive) begin
      if (next_r.op_n != 4'h0) begin
        next_r.dout = {3'h0, next_r.op_sh[7]};
        next_r.doe  = 4'h1;
      end else if (next_r.tx_n != 6'h00) begin
        next_r.dout = next_r.txq ? next_r.tx_sh[47:44] : {3'h0, next_r.tx_sh[47]};
        next_r.doe  = next_r.txq ? 4'hf : 4'h1;
      end else begin
        next_r.doe = 4'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      r <= HOST_RST;
    end else begin
      r <= next_r;
    end
  end

  assign hif.cs_n    = r.cs_n;
  assign hif.sclk    = r.sclk;
  assign hif.h_io_o  = r.dout;
  assign hif.h_io_oe = r.doe;
  assign ready_o     = r.ready;
  assign rd_data_o   = r.rdat;
  assign rd_valid_o  = r.rvalid;
  assign done_o      = r.done;
endmodule

// [tb/fwr_chk.sv]
`timescale 1ns/1ns
module fwr_chk (
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       reset_i,
  // Link
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_o,
  input wire logic [3:0] d_io_oe,
  input wire logic [3:0] io
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Serial clock rises seen in the current frame, saturating at 8
  logic [3:0] rise_cnt;
  logic       sclk_q;
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rise_cnt <= 4'h0;
      sclk_q   <= 1'b0;
    end else begin
      sclk_q <= sclk;
      if (cs_n)
        rise_cnt <= 4'h0;
      else if (sclk && !sclk_q && rise_cnt < 4'h8)
        rise_cnt <= rise_cnt + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence clk_parked;
    !sclk [*4];
  endsequence
  sequence high_half;
    sclk [*3];
  endsequence
  sequence low_half;
    !sclk [*3];
  endsequence

  chk_cs_setup: assert property ($fell(cs_n) |-> clk_parked)
    else $error("serial clock moved too soon after select");
  chk_sclk_high: assert property ($rose(sclk) |=> high_half)
    else $error("serial clock high phase too short");
  chk_sclk_low: assert property ($fell(sclk) |=> low_half)
    else $error("serial clock low phase too short");
  chk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock not idle low while deselected");
  chk_no_fight: assert property ((d_io_oe & h_io_oe) == 4'h0)
    else $error("both ends drive one data line");
  chk_opcode_quiet: assert property (!cs_n && rise_cnt < 4'h8 |-> d_io_oe == 4'h0)
    else $error("device drives during opcode phase");
  chk_dev_release: assert property (cs_n [*5] |-> d_io_oe == 4'h0)
    else $error("device still drives after deselect");
  chk_dev_stable: assert property ($fell(sclk) && d_io_oe != 4'h0 |-> $stable(d_io_o))
    else $error("device data moved at sampling fall");
  chk_host_stable: assert property ($rose(sclk) && h_io_oe != 4'h0 |-> $stable(h_io_o))
    else $error("host data moved at latching rise");
  chk_cs_gap: assert property ($rose(cs_n) |=> cs_n [*4])
    else $error("deselect gap too short");
endmodule

// [tb/fwr_bench.sv]
`timescale 1ns/1ns
module fwr_bench;
  localparam logic [7:0] MFR = 8'h5a;  // Arbitrary value
  localparam logic [7:0] DEV = 8'h3c;  // Arbitrary value
  logic        ref_clk_i, reset_i, cmd_valid, skip, busy, ready, rd_valid, done;
  logic        wrap_dis, pdown, cont, srst;
  logic [7:0]  opcode, wrap_byte, mode, read_bytes, sr2, rd_data;
  logic [23:0] addr, rd_addr;
  logic [1:0]  wrap_len;
  logic [7:0]  q[$];
  int          err_count, checks, srst_cnt;

  fwr_if lnk ();
  fwr_dev #(.MFR_ID(MFR), .DEV_ID(DEV)) u_fwr_dev (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .dif(lnk), .status_register_two_i(sr2), .busy_i(busy), .rd_data_i(rd_addr[7:0]),
    .rd_addr_o(rd_addr), .wrap_disable_o(wrap_dis), .wrap_length_o(wrap_len),
    .powered_down_o(pdown), .cont_read_o(cont), .soft_reset_o(srst));
  fwr_host u_fwr_host (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid),
    .opcode_i(opcode), .addr_i(addr), .wrap_byte_i(wrap_byte), .mode_i(mode),
    .skip_opcode_i(skip), .read_bytes_i(read_bytes), .ready_o(ready), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .done_o(done), .hif(lnk));
  fwr_chk u_fwr_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .cs_n(lnk.cs_n),
    .sclk(lnk.sclk), .h_io_o(lnk.h_io_o), .h_io_oe(lnk.h_io_oe), .d_io_o(lnk.d_io_o),
    .d_io_oe(lnk.d_io_oe), .io(lnk.io));

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  always @(posedge ref_clk_i) begin
    if (srst === 1'b1)
      srst_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // One command on the host port, bytes collected in q
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] w,
                     input logic [7:0] m, input logic sk, input logic [7:0] n);
    int i;
    q = {};
    opcode     <= op;
    addr       <= a;
    wrap_byte  <= w;
    mode       <= m;
    skip       <= sk;
    read_bytes <= n;
    cmd_valid  <= 1'b1;
    @(posedge ref_clk_i);
    cmd_valid <= 1'b0;
    for (i = 0; i < 30000; i++) begin
      @(posedge ref_clk_i);
      if (rd_valid === 1'b1)
        q.push_back(rd_data);
      if (done === 1'b1)
        break;
    end
    if (i == 30000) begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic rd_chk(input logic [23:0] base, input int size, input int off, input int n);
    chk(q.size(), n);
    for (int i = 0; i < n; i++)
      chk(q[i], 8'(base + 24'((off + i) % size)));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_i    = 1'b1;
    cmd_valid  = 1'b0;
    opcode     = 8'h00;
    addr       = 24'h0;
    wrap_byte  = 8'h00;
    mode       = 8'hff;
    skip       = 1'b0;
    read_bytes = 8'h00;
    sr2        = 8'h02;
    busy       = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(posedge ref_clk_i);
    chk(wrap_dis, 1'b1);
    chk(pdown, 1'b0);
    cmd(fwr_pkg::OP_QREAD, 24'h00003e, 8'h00, 8'hff, 1'b0, 8'h04);
    chk(ready, 1'b1);
    rd_chk(24'h0, 256, 62, 4);
    // Each wrap length, unused wrap bits set
    for (int k = 0; k < 4; k++) begin
      cmd(fwr_pkg::OP_WRAP, 24'h0, {1'b1, k[1:0], 1'b0, 4'hf}, 8'h00, 1'b0, 8'h00);
      chk(wrap_dis, 1'b0);
      chk(wrap_len, k);
      cmd(fwr_pkg::OP_QREAD, 24'h140 + 24'((8 << k) - 2), 8'h00, 8'hff, 1'b0, 8'((8 << k) + 2));
      rd_chk(24'h140, 8 << k, (8 << k) - 2, (8 << k) + 2);
    end
    // Quad commands without quad enable
    sr2 <= 8'h00;
    cmd(fwr_pkg::OP_WRAP, 24'h0, 8'h10, 8'h00, 1'b0, 8'h00);
    chk(wrap_dis, 1'b0);
    cmd(fwr_pkg::OP_QREAD, 24'h000040, 8'h00, 8'hff, 1'b0, 8'h01);
    chk(q[0], 8'hff);
    sr2 <= 8'h02;
    cmd(fwr_pkg::OP_QREAD, 24'h00017f, 8'h00, 8'hff, 1'b0, 8'h02);
    rd_chk(24'h140, 64, 63, 2);
    // Continuous read mode
    cmd(fwr_pkg::OP_QREAD, 24'h000200, 8'h00, 8'h20, 1'b0, 8'h01);
    chk(cont, 1'b1);
    cmd(fwr_pkg::OP_QREAD, 24'h000205, 8'h00, 8'h20, 1'b1, 8'h02);
    rd_chk(24'h200, 64, 5, 2);
    cmd(fwr_pkg::OP_RST_EN, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    cmd(fwr_pkg::OP_RST, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    chk(srst_cnt, 0);
    cmd(8'hff, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    chk(cont, 1'b0);
    // Deep power-down
    cmd(fwr_pkg::OP_PDOWN, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    waitc(int'(fwr_pkg::PDOWN_ENTRY_CYC) + 8);
    chk(pdown, 1'b1);
    cmd(fwr_pkg::OP_RST_EN, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    cmd(fwr_pkg::OP_RST, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    chk(srst_cnt, 0);
    cmd(fwr_pkg::OP_MFR_ID, 24'h0, 8'h00, 8'h00, 1'b0, 8'h01);
    chk(q[0], 8'hff);
    cmd(fwr_pkg::OP_RELEASE, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    waitc(int'(fwr_pkg::RELEASE_CYC) + 8);
    chk(pdown, 1'b0);
    chk(wrap_dis, 1'b0);
    // Identification reads
    for (int a = 0; a < 2; a++) begin
      cmd(fwr_pkg::OP_MFR_ID, 24'(a), 8'h00, 8'h00, 1'b0, 8'h04);
      for (int j = 0; j < 4; j++)
        chk(q[j], ((j + a) % 2 == 1) ? DEV : MFR);
    end
    cmd(fwr_pkg::OP_RELEASE, 24'h0, 8'h00, 8'h00, 1'b0, 8'h03);
    for (int j = 0; j < 3; j++)
      chk(q[j], DEV);
    waitc(int'(fwr_pkg::RELEASE_ID_CYC) + 8);
    busy <= 1'b1;
    cmd(fwr_pkg::OP_RELEASE, 24'h0, 8'h00, 8'h00, 1'b0, 8'h01);
    chk(q[0], 8'hff);
    busy <= 1'b0;
    // Reset pair broken, then whole
    // busy held clear before reset
    cmd(fwr_pkg::OP_RST_EN, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    cmd(8'hff, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    cmd(fwr_pkg::OP_RST, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    chk(srst_cnt, 0);
    cmd(fwr_pkg::OP_RST_EN, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    cmd(fwr_pkg::OP_RST, 24'h0, 8'h00, 8'h00, 1'b0, 8'h00);
    chk(srst_cnt, 1);
    chk(wrap_dis, 1'b1);
    chk(wrap_len, 2'h0);
    complete_run();
  end
endmodule
